// [design/char_lcd_host_interface.sv]
// Purpose: host port, RAMs and segment scan of a character LCD controller
// Assumes: one 20 MHz clock; every pin is asynchronous to it
// Notes:   glyph ROM content is a stand-in pattern generator
module char_lcd_host_interface
  import lcd_pkg::*;
#(
  parameter int BUSY_CYCLES = BUSY_CYC,        // Access time in clocks
  parameter int SCAN_DIVIDE = SCAN_DIV         // Scan tick divider
) (
  input  wire logic             ref_clk_i,
  input  wire logic             rst_i,
  input  wire par_ctl_t         par_ctl_i,
  input  wire logic [7:0]       db_i,
  output logic      [7:0]       db_o,
  output logic                  db_oe_o,
  input  wire logic             interface_select_hi_i,
  input  wire logic             interface_select_lo_i,
  input  wire ser_pins_t        ser_pins_i,
  output logic      [SEG_N-1:0] seg_o,
  output logic      [COM_N-1:0] com_o
);
  // Synchronised pins
  par_ctl_t     pc;                            // Bus control
  logic [7:0]   db_s;                          // Data lines
  logic [1:0]   ifs;                           // Interface select
  ser_pins_t    sp;                            // Serial pins

  sync2 #(.W(16), .RST_VAL(SYNC_RST)) u_sync (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .d_i       ({par_ctl_i, db_i, interface_select_hi_i,
                 interface_select_lo_i, ser_pins_i}),
    .q_o       ({pc, db_s, ifs, sp})
  );

  // Registers and state
  logic [7:0]   cmd_r;                         // Command register
  logic [7:0]   dr_r;                          // Data holding register
  logic [6:0]   ac_r;                          // RAM address counter
  logic         sel_cg_r;                      // 1 targets glyph RAM
  logic         dl_r;                          // Bus width bit
  logic         n_r;                           // Line count bit
  logic         id_r;                          // Increment mode
  logic [6:0]   off_r;                         // Display shift offset
  logic         busy_r;                        // Busy indicator
  logic [15:0]  busy_cnt_r;                    // Busy countdown
  nib_ph_t      ph_r;                          // Nibble phase
  logic [3:0]   wr_hi_r;                       // Held high nibble
  logic [7:0]   rd_byte_r;                     // Byte being read
  logic         en_d_r;                        // Delayed strobe
  logic         sclk_d_r;                      // Delayed serial clock
  logic [7:0]   ser_sh_r;                      // Serial shifter
  logic [3:0]   ser_cnt_r;                     // Serial bit count

  // Memories
  logic [7:0]   dd_mem [DD_DEPTH];             // Display text RAM
  logic [4:0]   cg_mem [CG_DEPTH];             // User glyph RAM

  // Text RAM index; second line packs after the first
  function automatic logic [6:0] dd_index(input logic [6:0] a, input logic two);
    dd_index = (two && a[6]) ? a - LINE2_SKIP : a;
  endfunction

  // Address is backed by storage in this line mode
  function automatic logic dd_ok(input logic [6:0] a, input logic two);
    dd_ok = two ? ({1'b0, a[5:0]} < LINE_LEN) : (a < DD_SIZE);
  endfunction

  // Next address counter value, with line wrap
  function automatic logic [6:0] ac_step(input logic [6:0] a, input logic up,
                                         input logic cg, input logic two);
    if (cg) begin
      ac_step = {1'b0, up ? a[5:0] + 6'h01 : a[5:0] - 6'h01};
    end else if (two) begin
      if (up) begin
        ac_step = (a == L1_LAST) ? L2_FIRST : (a == L2_LAST) ? 7'h00 : a + 7'h01;
      end else begin
        ac_step = (a == 7'h00) ? L2_LAST : (a == L2_FIRST) ? L1_LAST : a - 7'h01;
      end
    end else begin
      if (up) begin
        ac_step = (a == ONE_LAST) ? 7'h00 : a + 7'h01;
      end else begin
        ac_step = (a == 7'h00) ? ONE_LAST : a - 7'h01;
      end
    end
  endfunction

  // RAM read for prefetch into the data holding register
  function automatic logic [7:0] ram_rd(input logic [6:0] a, input logic cg,
                                        input logic two);
    if (cg) begin
      ram_rd = {3'h0, cg_mem[a[5:0]]};
    end else if (dd_ok(a, two)) begin
      ram_rd = dd_mem[dd_index(a, two)];
    end else begin
      ram_rd = 8'h00;
    end
  endfunction

  // Stand-in glyph ROM: 256 codes by 8 rows of 5 dots
  function automatic logic [4:0] rom_row(input logic [7:0] c, input logic [2:0] r);
    rom_row = (r == 3'h7) ? 5'h00 : (c[4:0] ^ {r, r[1:0]});
  endfunction

  // Mode decode
  logic par_mode;                              // Parallel bus active
  logic ser_mode;                              // Four-wire serial active
  assign par_mode = ifs[1];
  assign ser_mode = (ifs == IF_SER4);

  // Edge detection on synchronised strobes
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_d_r   <= 1'b0;
      sclk_d_r <= 1'b0;
    end else begin
      en_d_r   <= pc.en;
      sclk_d_r <= sp.sclk;
    end
  end

  logic en_rise, en_fall, sclk_rise;           // Strobe edges
  assign en_rise   = par_mode & pc.en & ~en_d_r;
  assign en_fall   = par_mode & ~pc.en & en_d_r;
  assign sclk_rise = ser_mode & sp.sclk & ~sclk_d_r;

  // Serial receiver: register select bit then 8 data bits
  logic ser_done;                              // Frame complete
  assign ser_done = sclk_rise & ~sp.serial_chip_select_n & (ser_cnt_r == SER_LAST);

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ser_sh_r  <= 8'h00;
      ser_cnt_r <= 4'h0;
    end else if (sp.serial_chip_select_n || !ser_mode) begin
      ser_cnt_r <= 4'h0;
    end else if (sclk_rise) begin
      ser_sh_r  <= {ser_sh_r[6:0], sp.serial_data_in};
      ser_cnt_r <= ser_done ? 4'h0 : ser_cnt_r + 4'h1;
    end
  end

  // Completed byte access from either port
  logic       par_last;                        // Strobe ends a byte
  logic       acc_v, acc_rs, acc_rw;           // Access and its kind
  logic [7:0] acc_byte;                        // Written byte
  assign par_last = dl_r | (ph_r == PH_LO);
  assign acc_v    = (en_fall & par_last) | ser_done;
  assign acc_rs   = ser_done ? ser_sh_r[7] : pc.register_select;
  assign acc_rw   = ser_done ? 1'b0 : pc.rw;
  assign acc_byte = ser_done ? {ser_sh_r[6:0], sp.serial_data_in} :
                    dl_r ? db_s : {wr_hi_r, db_s[7:4]};

  logic wr_ok, cmd_wr, dat_wr, dat_rd;
  assign wr_ok  = acc_v & ~acc_rw & ~busy_r;
  assign cmd_wr = wr_ok & ~acc_rs;
  assign dat_wr = wr_ok & acc_rs;
  assign dat_rd = acc_v & acc_rw & acc_rs & ~busy_r;

  // Nibble phase and held high nibble
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ph_r    <= PH_HI;
      wr_hi_r <= 4'h0;
    end else if (dl_r || !par_mode) begin
      ph_r    <= PH_HI;
    end else if (en_fall) begin
      if (ph_r == PH_HI) begin
        wr_hi_r <= db_s[7:4];
        ph_r    <= PH_LO;
      end else begin
        ph_r    <= PH_HI;
      end
    end
  end

  // Read data driver; byte is caught on the first strobe
  logic [7:0] rd_src;                          // Byte offered to host
  assign rd_src = pc.register_select ? dr_r : {busy_r, ac_r};

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      db_o      <= 8'h00;
      db_oe_o   <= 1'b0;
      rd_byte_r <= 8'h00;
    end else if (en_rise && pc.rw) begin
      db_oe_o <= 1'b1;
      if (dl_r) begin
        db_o <= rd_src;
      end else if (ph_r == PH_HI) begin
        rd_byte_r <= rd_src;
        db_o      <= {rd_src[7:4], 4'h0};
      end else begin
        db_o <= {rd_byte_r[3:0], 4'h0};
      end
    end else if (en_fall || !par_mode) begin
      db_oe_o <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      busy_r     <= 1'b0;
      busy_cnt_r <= 16'h0000;
    end else if (wr_ok || dat_rd) begin
      busy_r     <= 1'b1;
      busy_cnt_r <= 16'(BUSY_CYCLES - 1);
    end else if (busy_r) begin
      if (busy_cnt_r == 16'h0000) begin
        busy_r <= 1'b0;
      end else begin
        busy_cnt_r <= busy_cnt_r - 16'h0001;
      end
    end
  end

  // Command register and mode bits
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cmd_r <= 8'h00;
      dl_r  <= DL_RST;
      n_r   <= N_RST;
      id_r  <= ID_RST;
      off_r <= 7'h00;
    end else if (cmd_wr) begin
      cmd_r <= acc_byte;
      if (!acc_byte[CMD_DD_BIT] && !acc_byte[CMD_CG_BIT]) begin
        if (acc_byte[CMD_FN_BIT]) begin
          dl_r  <= acc_byte[FN_DL_BIT];
          n_r   <= acc_byte[FN_N_BIT];
          off_r <= 7'h00;
        end else if (acc_byte[CMD_SH_BIT] && acc_byte[SH_SC_BIT]) begin
          if (acc_byte[SH_RL_BIT]) begin
            off_r <= (off_r == 7'h00) ? (n_r ? LINE_LEN : DD_SIZE) - 7'h01
                                      : off_r - 7'h01;
          end else begin
            off_r <= (off_r == (n_r ? LINE_LEN : DD_SIZE) - 7'h01) ? 7'h00
                                                                   : off_r + 7'h01;
          end
        end else if (acc_byte[CMD_EN_BIT] && !acc_byte[CMD_SH_BIT]) begin
          id_r <= acc_byte[EN_ID_BIT];
        end
      end
    end
  end

  // Address counter, RAM target and data holding register
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ac_r     <= 7'h00;
      sel_cg_r <= 1'b0;
      dr_r     <= 8'h00;
    end else if (cmd_wr && acc_byte[CMD_DD_BIT]) begin
      ac_r     <= acc_byte[6:0];
      sel_cg_r <= 1'b0;
      dr_r     <= ram_rd(acc_byte[6:0], 1'b0, n_r);
    end else if (cmd_wr && acc_byte[CMD_CG_BIT]) begin
      ac_r     <= {1'b0, acc_byte[5:0]};
      sel_cg_r <= 1'b1;
      dr_r     <= ram_rd({1'b0, acc_byte[5:0]}, 1'b1, n_r);
    end else if (cmd_wr && acc_byte[CMD_SH_BIT] && !acc_byte[CMD_FN_BIT]
                 && !acc_byte[SH_SC_BIT]) begin
      ac_r <= ac_step(ac_r, acc_byte[SH_RL_BIT], sel_cg_r, n_r);
    end else if (dat_wr) begin
      dr_r <= acc_byte;
      ac_r <= ac_step(ac_r, id_r, sel_cg_r, n_r);
    end else if (dat_rd) begin
      ac_r <= ac_step(ac_r, id_r, sel_cg_r, n_r);
      dr_r <= ram_rd(ac_step(ac_r, id_r, sel_cg_r, n_r), sel_cg_r, n_r);
    end
  end

  // copy written byte into RAM
  // Cleared at reset so scan and prefetch never meet unknown contents
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < DD_DEPTH; i++) begin
        dd_mem[i] <= 8'h00;
      end
      for (int i = 0; i < CG_DEPTH; i++) begin
        cg_mem[i] <= 5'h00;
      end
    end else if (dat_wr && sel_cg_r) begin
      cg_mem[ac_r[5:0]] <= acc_byte[4:0];
    end else if (dat_wr && dd_ok(ac_r, n_r)) begin
      dd_mem[dd_index(ac_r, n_r)] <= acc_byte;
    end
  end

  // Scan tick divider
  logic [15:0] div_r;                          // Divider count
  logic        tick;                           // Scan enable pulse
  assign tick = (div_r == 16'(SCAN_DIVIDE - 1));

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_r <= 16'h0000;
    end else begin
      div_r <= tick ? 16'h0000 : div_r + 16'h0001;
    end
  end

  // Scan position and glyph fetch
  logic [3:0]  com_r;                          // Common row index
  logic [2:0]  chr_r;                          // Character in row
  logic [2:0]  bit_r;                          // Dot in character
  logic [39:0] seg_sh_r;                       // Segment shift latches
  logic [6:0]  col_sum, col, scan_a;           // Scan addressing
  logic [7:0]  code;                           // Character code
  logic [4:0]  pat;                            // Glyph row dots
  logic        dot;                            // Dot being shifted
  logic        row_end;                        // Last dot of a row

  assign col_sum = {4'h0, chr_r} + off_r;
  assign col     = (col_sum >= (n_r ? LINE_LEN : DD_SIZE)) ?
                   col_sum - (n_r ? LINE_LEN : DD_SIZE) : col_sum;
  assign scan_a  = n_r ? {com_r[3], col[5:0]} : col;
  // Process form, so RAM writes behind the function call are seen
  always_comb begin
    code = ram_rd(scan_a, 1'b0, n_r);
  end
  // ROM unless code upper nibble zero
  assign pat     = (code[7:4] == 4'h0) ? cg_mem[{code[2:0], com_r[2:0]}]
                                       : rom_row(code, com_r[2:0]);
  assign dot     = pat[3'(GLYPH_W - 1) - bit_r];
  assign row_end = (chr_r == 3'h7) && (bit_r == 3'(GLYPH_W - 1));

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      chr_r    <= 3'h0;
      bit_r    <= 3'h0;
      com_r    <= 4'h0;
      seg_sh_r <= 40'h0;
      seg_o    <= 40'h0;
      com_o    <= 16'h0000;
    end else if (tick) begin
      seg_sh_r <= {seg_sh_r[38:0], dot};
      if (bit_r == 3'(GLYPH_W - 1)) begin
        bit_r <= 3'h0;
        chr_r <= chr_r + 3'h1;
      end else begin
        bit_r <= bit_r + 3'h1;
      end
      if (row_end) begin
        seg_o <= {seg_sh_r[38:0], dot};
        com_o <= 16'h0001 << com_r;
        com_r <= (com_r == (n_r ? 4'hf : 4'h7)) ? 4'h0 : com_r + 4'h1;
      end
    end
  end

  property p_busy_len;
    @(posedge ref_clk_i) disable iff (rst_i)
    $rose(busy_r) |-> ##[369:369] busy_r ##1 !busy_r;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("busy length wrong");

  property p_busy_refuse;
    @(posedge ref_clk_i) disable iff (rst_i)
    (acc_v && !acc_rw && !acc_rs && busy_r) |=> $stable(cmd_r) && $stable(ac_r);
  endproperty
  a_busy_refuse: assert property (p_busy_refuse)
    else $error("command taken while busy");

  property p_status;
    @(posedge ref_clk_i) disable iff (rst_i)
    (en_rise && pc.rw && !pc.register_select && dl_r)
      |=> db_oe_o && db_o == {$past(busy_r), $past(ac_r)};
  endproperty
  a_status: assert property (p_status)
    else $error("status read wrong");

  property p_ac_load;
    @(posedge ref_clk_i) disable iff (rst_i)
    (cmd_wr && acc_byte[CMD_DD_BIT]) |=> ac_r == $past(acc_byte[6:0]) && !sel_cg_r;
  endproperty
  a_ac_load: assert property (p_ac_load)
    else $error("address not loaded");

  property p_step;
    @(posedge ref_clk_i) disable iff (rst_i)
    (dat_wr && !sel_cg_r && ac_r != 7'h00 && ac_r != L1_LAST && ac_r != L2_FIRST
     && ac_r < ONE_LAST)
      |=> ac_r == ($past(id_r) ? $past(ac_r) + 7'h01 : $past(ac_r) - 7'h01);
  endproperty
  a_step: assert property (p_step)
    else $error("counter did not step");

  property p_prefetch;
    @(posedge ref_clk_i) disable iff (rst_i)
    dat_rd ##1 !cmd_wr ##1 !dat_wr |-> dr_r == $past(ram_rd(ac_r, sel_cg_r, n_r));
  endproperty
  a_prefetch: assert property (p_prefetch)
    else $error("prefetch missing");

  property p_nibble;
    @(posedge ref_clk_i) disable iff (rst_i)
    (en_fall && !dl_r && ph_r == PH_HI) |-> !acc_v ##1 (ph_r == PH_LO);
  endproperty
  a_nibble: assert property (p_nibble)
    else $error("nibble order wrong");

  property p_serial_quiet;
    @(posedge ref_clk_i) disable iff (rst_i)
    !par_mode |=> !db_oe_o;
  endproperty
  a_serial_quiet: assert property (p_serial_quiet)
    else $error("bus driven in serial mode");

  property p_deselect;
    @(posedge ref_clk_i) disable iff (rst_i)
    sp.serial_chip_select_n |=> ser_cnt_r == 4'h0 && !ser_done;
  endproperty
  a_deselect: assert property (p_deselect)
    else $error("serial active while deselected");

  property p_latch;
    @(posedge ref_clk_i) disable iff (rst_i)
    (tick && row_end) |=> seg_o == $past({seg_sh_r[38:0], dot}) && $onehot(com_o);
  endproperty
  a_latch: assert property (p_latch)
    else $error("segment latch wrong");
endmodule // char_lcd_host_interface

// [design/lcd_pkg.sv]
// Purpose: shared constants and types of the character LCD host port
// Assumes: 20 MHz core clock
// Notes:   command bit positions are fixed here for the whole design
package lcd_pkg;
  // Timing
  localparam int CLK_NS     = 50;              // Core clock period
  localparam int CLK_KHZ    = 20000;           // Core clock rate
  localparam int OSC_KHZ    = 540;             // Nominal internal oscillator
  localparam int ACCESS_NS  = 18500;           // Longest RAM access time
  localparam int BUSY_CYC   = ACCESS_NS / CLK_NS;  // Rounds down
  localparam int SCAN_DIV   = CLK_KHZ / OSC_KHZ;   // Scan tick divider
  // Memory sizes
  localparam int DD_DEPTH   = 80;              // Display text RAM bytes
  localparam int CG_DEPTH   = 64;              // User glyph RAM rows
  localparam int ROM_CHARS  = 256;             // Glyph ROM patterns
  localparam int ROM_BITS   = ROM_CHARS * 8 * 5;   // Glyph ROM size
  localparam int SEG_N      = 40;              // Segment outputs
  localparam int COM_N      = 16;              // Common outputs
  localparam int GLYPH_W    = 5;               // Dots per glyph row
  // Display text RAM addressing
  localparam logic [6:0] DD_SIZE    = 7'h50;   // One-line length
  localparam logic [6:0] LINE_LEN   = 7'h28;   // Two-line length
  localparam logic [6:0] LINE2_SKIP = 7'h18;   // 0x40 minus 40
  localparam logic [6:0] L1_LAST    = 7'h27;   // End of first line
  localparam logic [6:0] L2_FIRST   = 7'h40;   // Start of second line
  localparam logic [6:0] L2_LAST    = 7'h67;   // End of second line
  localparam logic [6:0] ONE_LAST   = 7'h4f;   // End in one-line mode
  // Command opcode bits and fields
  localparam int CMD_DD_BIT   = 7;             // Set text RAM address
  localparam int CMD_CG_BIT   = 6;             // Set glyph RAM address
  localparam int CMD_FN_BIT   = 5;             // Function set
  localparam int CMD_SH_BIT   = 4;             // Cursor or display shift
  localparam int CMD_EN_BIT   = 2;             // Entry mode
  localparam int FN_DL_BIT    = 4;             // Bus width bit
  localparam int FN_N_BIT     = 3;             // Line count bit
  localparam int SH_SC_BIT    = 3;             // 1 shifts display
  localparam int SH_RL_BIT    = 2;             // 1 shifts right
  localparam int EN_ID_BIT    = 1;             // 1 increments
  // Reset values
  localparam logic DL_RST = 1'b1;              // 8-bit bus
  localparam logic N_RST  = 1'b0;              // One line
  localparam logic ID_RST = 1'b1;              // Increment
  // Interface select codes
  localparam logic [1:0] IF_SER4 = 2'b01;      // Four-wire serial
  localparam logic [3:0] SER_LAST = 4'h8;      // Last bit index of frame
  localparam logic [15:0] SYNC_RST = 16'h0004; // Chip select idles high

  typedef enum logic {PH_HI = 1'b0, PH_LO = 1'b1} nib_ph_t;

  typedef struct packed {
    logic register_select;                     // 1 data, 0 command
    logic rw;                                  // 1 read
    logic en;                                  // Bus enable strobe
  } par_ctl_t;

  typedef struct packed {
    logic serial_chip_select_n;                // Active low select
    logic sclk;                                // Serial clock
    logic serial_data_in;                      // Serial data
  } ser_pins_t;
endpackage

// [design/sync2.sv]
// Purpose: two-stage synchroniser for asynchronous pins
// Assumes: single clock, asynchronous active-high reset
// Notes:   first stage feeds only the second stage
module sync2 #(
  parameter int              W       = 1,
  parameter logic [W-1:0]    RST_VAL = '0
) (
  input  wire logic          ref_clk_i,
  input  wire logic          rst_i,
  input  wire logic [W-1:0]  d_i,
  output logic      [W-1:0]  q_o
);
  logic [W-1:0] meta_r;                        // First stage

  // Two flops in series
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_r <= RST_VAL;
      q_o    <= RST_VAL;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule // sync2

// [sim/lcd_host_model.sv]
// Purpose: host processor model on the parallel bus and serial pins
// Assumes: 8-bit or 4-bit bus, strobe held 6 clocks high and 6 low
// Notes:   released data lines show the inverse of the last value
module lcd_host_model
  import lcd_pkg::*;
(
  input  wire logic       ref_clk_i,
  output par_ctl_t        par_ctl_o,
  output ser_pins_t       ser_o,
  output logic [7:0]      db_o,
  input  wire logic [7:0] db_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic wide = 1'b1;                       // 8-bit bus in use
  initial begin
    par_ctl_o = '0;
    ser_o = '{serial_chip_select_n: 1'b1, sclk: 1'b0, serial_data_in: 1'b0};
    db_o = 8'h00;
  end
  // One strobe; select lines held from before rise to after fall
  task automatic strobe(input logic rs, input logic rw, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge ref_clk_i);
    par_ctl_o <= '{register_select: rs, rw: rw, en: 1'b0};
    db_o <= d;
    repeat (2) @(posedge ref_clk_i);
    par_ctl_o.en <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    q = db_i;
    par_ctl_o.en <= 1'b0;
    repeat (6) @(posedge ref_clk_i);
    db_o <= ~d;
  endtask
  // One byte: one strobe, or two nibbles on the upper lines
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] d,
                      output logic [7:0] q);
    logic [7:0] h;
    if (wide) begin
      strobe(rs, rw, d, q);
    end else begin
      strobe(rs, rw, {d[7:4], 4'h0}, h);
      strobe(rs, rw, {d[3:0], 4'h0}, q);
      q = {h[7:4], q[7:4]};
    end
  endtask
  task automatic ser_wr(input logic cs_n, input logic rs, input logic [7:0] d);
    logic [8:0] f;
    f = {rs, d};
    @(posedge ref_clk_i);
    ser_o.serial_chip_select_n <= cs_n;
    for (int i = 8; i >= 0; i--) begin
      repeat (3) @(posedge ref_clk_i);
      ser_o.serial_data_in <= f[i];
      ser_o.sclk           <= 1'b0;
      repeat (3) @(posedge ref_clk_i);
      ser_o.sclk <= 1'b1;
    end
    repeat (3) @(posedge ref_clk_i);
    ser_o <= '{serial_chip_select_n: 1'b1, sclk: 1'b0, serial_data_in: 1'b0};
    repeat (400) @(posedge ref_clk_i);
  endtask
  task automatic acc(input logic rs, input logic rw, input logic [7:0] d,
                     output logic [7:0] q);
    logic [7:0] s;
    s = 8'h80;
    for (int i = 0; i < 100 && s[7] !== 1'b0; i++) begin
      xfer(1'b0, 1'b1, 8'h00, s);
    end
    xfer(rs, rw, d, q);
  endtask
endmodule // lcd_host_model

// [sim/tb.sv]
// Purpose: self-checking bench of the host port
// Assumes: parallel 8-bit bus first, default busy length
// Notes:   serial and 4-bit bus exercised near the end
module tb
  import lcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       ref_clk_i = 1'b0;
  logic       rst_i     = 1'b1;
  par_ctl_t   par_ctl;
  ser_pins_t  ser;
  logic [1:0] ifs       = 2'b10;
  logic       oe;
  logic [COM_N-1:0] com;
  logic [7:0] db_w, db_r, db_bus, q;
  int         n_errors  = 0;
  int         tests_run = 0;
  int         cyc       = 0;
  always #25 ref_clk_i = ~ref_clk_i;
  // Released data lines read back inverted
  assign db_bus = oe ? db_r : ~db_r;
  char_lcd_host_interface #(.SCAN_DIVIDE(2)) u_char_lcd_host_interface (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .par_ctl_i(par_ctl), .db_i(db_w),
    .db_o(db_r), .db_oe_o(oe), .interface_select_hi_i(ifs[1]),
    .interface_select_lo_i(ifs[0]), .ser_pins_i(ser), .seg_o(), .com_o(com));
  lcd_host_model u_lcd_host_model (
    .ref_clk_i(ref_clk_i), .par_ctl_o(par_ctl), .ser_o(ser), .db_o(db_w),
    .db_i(db_bus));
  // Compare one value
  task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic acc(input logic rs, input logic rw, input logic [7:0] d);
    u_lcd_host_model.acc(rs, rw, d, q);
  endtask
  // Hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    acc(0, 1, 8'h00); chk("status", q, 8'h00);
    acc(0, 0, 8'h38);
    acc(0, 0, 8'ha7);
    acc(1, 0, 8'h5a);
    u_lcd_host_model.xfer(0, 1, 8'h00, q); chk("busy_ac", q, 8'hc0);
    // Command sent while busy must be dropped
    u_lcd_host_model.xfer(0, 0, 8'h80, q);
    acc(0, 1, 8'h00); chk("refused", q, 8'h40);
    acc(0, 0, 8'ha7);
    acc(1, 1, 8'h00); chk("text_rd", q, 8'h5a);
    u_lcd_host_model.xfer(0, 1, 8'h00, q); chk("rd_step", q, 8'hc0);
    acc(0, 0, 8'h40);
    acc(1, 0, 8'hff);
    acc(0, 0, 8'h40);
    acc(1, 1, 8'h00); chk("glyph_rd", q, 8'h1f);
    acc(0, 0, 8'h04);
    acc(0, 0, 8'h85);
    acc(1, 0, 8'h33);
    acc(0, 1, 8'h00); chk("dec_ac", q, 8'h04);
    acc(0, 0, 8'h86);
    acc(1, 1, 8'h00); chk("prefetch", q, 8'h00);
    acc(1, 1, 8'h00); chk("prefetch2", q, 8'h33);
    // Serial: address set, an ignored deselected frame, then data
    acc(0, 1, 8'h00);
    ifs <= 2'b01;
    u_lcd_host_model.ser_wr(1'b0, 1'b0, 8'h90);
    u_lcd_host_model.ser_wr(1'b1, 1'b0, 8'h95);
    u_lcd_host_model.ser_wr(1'b0, 1'b1, 8'h4e);
    ifs <= 2'b10;
    acc(0, 0, 8'h90);
    acc(1, 1, 8'h00); chk("serial", q, 8'h4e);
    // Four-bit bus, then back to eight bits
    acc(0, 0, 8'h28);
    u_lcd_host_model.wide = 1'b0;
    acc(0, 0, 8'h85);
    acc(1, 0, 8'hc3);
    acc(0, 0, 8'h85);
    acc(1, 1, 8'h00); chk("nibble_rd", q, 8'hc3);
    acc(0, 1, 8'h00); chk("nibble_ac", q, 8'h04);
    acc(0, 0, 8'h38);
    u_lcd_host_model.wide = 1'b1;
    acc(0, 1, 8'h00); chk("wide_ac", q, 8'h04);
    chk("oe_idle", {7'h00, oe}, 8'h00);
    chk("com_row", {7'h00, $onehot(com)}, 8'h01);
    report_and_stop();
  end
endmodule // tb
